/* File: hw/ifec_top.v */
/*
  Interrupt flag and enable slice with a classic Wishbone slave. It holds the
  second control register, three flag registers, the first enable register
  and one priority word per source of the first flag register, and presents
  the highest-priority pending enabled request to the core.
  Assumes all inputs are synchronous to clk_i, peripheral request inputs are
  one-cycle pulses (a held level simply keeps its flag set), and the core
  drives the interrupt-disable status as a level.
*/
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ifec_consts.vh"

module ifec_top #(
  parameter ADR_W = 8
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADR_W-1:0]  wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire [15:0]       flags_zero_req_i,
  input  wire [15:0]       flags_one_req_i,
  input  wire [15:0]       flags_four_req_i,
  input  wire [2:0]        ext_pin_i,
  input  wire              irq_hold_instr_active_i,
  output reg               alt_vector_select_o,
  output reg               irq_req_o,
  output reg  [2:0]        irq_level_o,
  output reg  [3:0]        irq_src_o
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [15:0] interrupt_flags_zero;
  reg  [15:0] interrupt_flags_one;
  reg  [15:0] interrupt_flags_four;
  reg  [15:0] interrupt_enables_zero;
  reg  [2:0]  ext_edge_polarity;
  reg         irq_hold_instr_active;
  reg  [2:0]  prio [0:15];
  reg  [2:0]  pin_prev;
  reg         pin_primed;

  reg  [15:0] next_flags_zero;
  reg  [15:0] next_flags_one;
  reg  [15:0] next_flags_four;
  reg  [15:0] next_enables_zero;
  reg  [31:0] next_rdata;
  reg  [2:0]  next_level;
  reg  [3:0]  next_src;

  wire [15:0] ctl_two_rd;
  wire [15:0] wmask;
  wire [15:0] pending;
  wire [2:0]  pin_rise;
  wire [2:0]  pin_fall;
  wire [2:0]  pin_edge;
  wire [15:0] set_zero;
  wire [15:0] set_one;
  wire [15:0] set_four;
  wire        wr_commit;
  wire        hit_prio;
  wire [3:0]  prio_idx;
  wire [7:0]  byte_adr;

  integer i;
  integer j;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------

  // A write lands on the edge at which the master samples ack high, so the
  // register changes exactly once per transfer even if the master is slow.
  assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign byte_adr  = wb_adr_i[7:0];
  assign hit_prio  = (byte_adr[7:6] == `IFEC_PRIO_SEL_HI);
  assign prio_idx  = byte_adr[5:2];

  // Only the low two byte lanes carry register data.
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Status bit 14 follows the core; bits 13 to 3 are tied low.
  assign ctl_two_rd = {alt_vector_select_o,
                       irq_hold_instr_active,
                       11'h000,
                       ext_edge_polarity};

  // --------------------------------------------------------------------------
  // External pin edge detection
  // --------------------------------------------------------------------------

  // The first cycle after reset only loads the previous-level flops, so a pin
  // that is already high at reset does not fake a rising edge.
  assign pin_rise = ext_pin_i & ~pin_prev & {3{pin_primed}};
  assign pin_fall = ~ext_pin_i & pin_prev & {3{pin_primed}};
  assign pin_edge[0] = ext_edge_polarity[`IFEC_CTL_EXT0_POL] ?
                       pin_fall[0] : pin_rise[0];
  assign pin_edge[1] = ext_edge_polarity[`IFEC_CTL_EXT1_POL] ?
                       pin_fall[1] : pin_rise[1];
  assign pin_edge[2] = ext_edge_polarity[`IFEC_CTL_EXT2_POL] ?
                       pin_fall[2] : pin_rise[2];

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev   <= 3'h0;
      pin_primed <= 1'b0;
    end else begin
      pin_prev   <= ext_pin_i;
      pin_primed <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Set terms for the flags
  // --------------------------------------------------------------------------

  // Peripheral requests land on their documented bit; the pin bits are fed
  // from the edge detector instead of the request inputs.
  assign set_zero = (flags_zero_req_i & `IFEC_F0_MASK &
                     ~(16'h0001 << `IFEC_F0_EXT_ZERO)) |
                    ({15'h0000, pin_edge[0]} << `IFEC_F0_EXT_ZERO);
  assign set_one  = (flags_one_req_i & `IFEC_F1_MASK &
                     ~(16'h0001 << `IFEC_F1_EXT_ONE) &
                     ~(16'h0001 << `IFEC_F1_EXT_TWO)) |
                    ({15'h0000, pin_edge[1]} << `IFEC_F1_EXT_ONE) |
                    ({15'h0000, pin_edge[2]} << `IFEC_F1_EXT_TWO);
  assign set_four = flags_four_req_i & `IFEC_F4_MASK;

  // --------------------------------------------------------------------------
  // Next values of the flag and enable registers
  // --------------------------------------------------------------------------

  // A software write replaces the addressed lanes, then the set terms are
  // ORed in, so a request arriving during a clearing write is never lost.
  always @* begin
    next_flags_zero   = interrupt_flags_zero;
    next_flags_one    = interrupt_flags_one;
    next_flags_four   = interrupt_flags_four;
    next_enables_zero = interrupt_enables_zero;
    if (wr_commit && byte_adr == `IFEC_OFS_FLAGS_ZERO) begin
      next_flags_zero = (interrupt_flags_zero & ~wmask) | (wb_dat_i[15:0] & wmask);
    end
    if (wr_commit && byte_adr == `IFEC_OFS_FLAGS_ONE) begin
      next_flags_one = (interrupt_flags_one & ~wmask) | (wb_dat_i[15:0] & wmask);
    end
    if (wr_commit && byte_adr == `IFEC_OFS_FLAGS_FOUR) begin
      next_flags_four = (interrupt_flags_four & ~wmask) | (wb_dat_i[15:0] & wmask);
    end
    if (wr_commit && byte_adr == `IFEC_OFS_EN_ZERO) begin
      next_enables_zero = (interrupt_enables_zero & ~wmask) |
                          (wb_dat_i[15:0] & wmask);
    end
    // Unimplemented positions never hold a one.
    next_flags_zero   = (next_flags_zero | set_zero) & `IFEC_F0_MASK;
    next_flags_one    = (next_flags_one  | set_one)  & `IFEC_F1_MASK;
    next_flags_four   = (next_flags_four | set_four) & `IFEC_F4_MASK;
    next_enables_zero = next_enables_zero & `IFEC_EN0_MASK;
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_flags_zero   <= `IFEC_RST_REG16;
      interrupt_flags_one    <= `IFEC_RST_REG16;
      interrupt_flags_four   <= `IFEC_RST_REG16;
      interrupt_enables_zero <= `IFEC_RST_REG16;
      ext_edge_polarity      <= 3'h0;
      alt_vector_select_o    <= 1'b0;
      irq_hold_instr_active  <= 1'b0;
    end else begin
      interrupt_flags_zero   <= next_flags_zero;
      interrupt_flags_one    <= next_flags_one;
      interrupt_flags_four   <= next_flags_four;
      interrupt_enables_zero <= next_enables_zero;
      irq_hold_instr_active  <= irq_hold_instr_active_i;
      if (wr_commit && byte_adr == `IFEC_OFS_CTL_TWO && wb_sel_i[1]) begin
        alt_vector_select_o <= wb_dat_i[`IFEC_CTL_ALT_VEC];
      end
      if (wr_commit && byte_adr == `IFEC_OFS_CTL_TWO && wb_sel_i[0]) begin
        ext_edge_polarity <= wb_dat_i[2:0];
      end
    end
  end

  // Priority words, one per source of the first flag register.
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 16; i = i + 1) begin
        prio[i] <= `IFEC_RST_PRIO;
      end
    end else if (wr_commit && hit_prio && wb_sel_i[0]) begin
      prio[prio_idx] <= wb_dat_i[2:0];
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------

  // Unmapped addresses answer with zero so software sees a defined value.
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_prio) begin
      next_rdata = {29'h0000_0000, prio[prio_idx]};
    end else begin
      case (byte_adr)
        `IFEC_OFS_CTL_TWO: begin
          next_rdata = {16'h0000, ctl_two_rd};
        end
        `IFEC_OFS_FLAGS_ZERO: begin
          next_rdata = {16'h0000, interrupt_flags_zero};
        end
        `IFEC_OFS_FLAGS_ONE: begin
          next_rdata = {16'h0000, interrupt_flags_one};
        end
        `IFEC_OFS_FLAGS_FOUR: begin
          next_rdata = {16'h0000, interrupt_flags_four};
        end
        `IFEC_OFS_EN_ZERO: begin
          next_rdata = {16'h0000, interrupt_enables_zero};
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Wishbone answer
  // --------------------------------------------------------------------------

  // Ack follows the request by one cycle and drops the cycle after, which
  // keeps a held request from being acknowledged in two cycles in a row.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request arbitration
  // --------------------------------------------------------------------------

  // Only the first flag register has enables in this slice, so only its
  // sources can reach the core.
  assign pending = interrupt_flags_zero & interrupt_enables_zero;

  // Highest level wins; on a tie the lower source index wins. A level of
  // zero never wins, which disables the source outright.
  always @* begin
    next_level = `IFEC_PRIO_OFF;
    next_src   = 4'h0;
    // A loop index of its own, so no variable is shared with a clocked process.
    for (j = 0; j < 16; j = j + 1) begin
      if (pending[j] && prio[j] > next_level) begin
        next_level = prio[j];
        next_src   = j[3:0];
      end
    end
  end

  // Outputs are registered, so the core sees a new flag one cycle after it
  // is latched; the trade is a cycle of latency for a clean timing path.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o   <= 1'b0;
      irq_level_o <= `IFEC_PRIO_OFF;
      irq_src_o   <= 4'h0;
    end else begin
      irq_req_o   <= (next_level != `IFEC_PRIO_OFF);
      irq_level_o <= next_level;
      irq_src_o   <= next_src;
    end
  end

endmodule

/* File: pkg/ifec_consts.vh */
/*
  Constants for the interrupt flag and enable slice: register byte offsets,
  field positions, implemented-bit masks, reset values and the priority field.
  Assumes it is included by its bare name from the design files.
*/
`ifndef IFEC_CONSTS_VH
`define IFEC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define IFEC_OFS_CTL_TWO    8'h00
`define IFEC_OFS_FLAGS_ZERO 8'h04
`define IFEC_OFS_FLAGS_ONE  8'h08
`define IFEC_OFS_FLAGS_FOUR 8'h0c
`define IFEC_OFS_EN_ZERO    8'h10
`define IFEC_OFS_PRIO_BASE  8'h40
`define IFEC_PRIO_SEL_HI    2'h1

// ----------------------------------------------------------------------------
// Control register two fields
// ----------------------------------------------------------------------------
`define IFEC_CTL_ALT_VEC    15
`define IFEC_CTL_HOLD_INSTR 14
`define IFEC_CTL_EXT2_POL   2
`define IFEC_CTL_EXT1_POL   1
`define IFEC_CTL_EXT0_POL   0
`define IFEC_CTL_WR_MASK    16'h8007

// ----------------------------------------------------------------------------
// Flag and enable positions for the external pins
// ----------------------------------------------------------------------------
`define IFEC_F0_EXT_ZERO    0
`define IFEC_F1_EXT_ONE     4
`define IFEC_F1_EXT_TWO     13

// ----------------------------------------------------------------------------
// Implemented-bit masks
// ----------------------------------------------------------------------------
`define IFEC_F0_MASK        16'h3fef
`define IFEC_F1_MASK        16'h20db
`define IFEC_F4_MASK        16'h0002
`define IFEC_EN0_MASK       16'h3fef

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IFEC_RST_REG16      16'h0000
`define IFEC_RST_PRIO       3'h4
`define IFEC_PRIO_OFF       3'h0

`endif

/* File: dv/ifec_top_monitor.sv */
/* Checker for the interrupt flag and enable slice.
   Sees only the ports of ifec_top and is bound to every instance of it. */
`timescale 1ns/1ns
module ifec_top_monitor #(
  parameter ADR_W = 8
) (
  input wire             clk_i,
  input wire             rst_i,
  input wire             wb_cyc_i,
  input wire             wb_stb_i,
  input wire             wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0]       wb_sel_i,
  input wire [31:0]      wb_dat_i,
  input wire [31:0]      wb_dat_o,
  input wire             wb_ack_o,
  input wire [15:0]      flags_zero_req_i,
  input wire [15:0]      flags_one_req_i,
  input wire [15:0]      flags_four_req_i,
  input wire [2:0]       ext_pin_i,
  input wire             irq_hold_instr_active_i,
  input wire             alt_vector_select_o,
  input wire             irq_req_o,
  input wire [2:0]       irq_level_o,
  input wire [3:0]       irq_src_o
);
  // ----------
  // Bus and read-back checks
  // ----------
  // Unimplemented bits per register; a wrong mask in the design shows here.
  wire [5:0]  wa = wb_adr_i[7:2];
  wire        rd = wb_ack_o && !wb_we_i;
  wire [15:0] um = (wa == 1 || wa == 4) ? 16'hc010 : (wa == 2) ? 16'hdf24 :
                   (wa == 3) ? 16'hfffd : 16'h0000;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after a taken request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  a_ctl_reserved: assert property (rd && wa == 0 |-> wb_dat_o[13:3] == 11'h000)
    else $error("control middle bits not zero");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_unimpl_zero: assert property (rd |-> (wb_dat_o[15:0] & um) == 16'h0000)
    else $error("unimplemented flag or enable bit set");
  a_unmapped_zero: assert property (rd && wa > 4 && wa < 16 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_prio_width: assert property (rd && wa > 15 |-> wb_dat_o[15:3] == 13'h0000)
    else $error("priority word wider than three bits");
  a_alt_write: assert property (wb_ack_o && wb_we_i && wa == 0 && wb_sel_i[1]
    |=> alt_vector_select_o == $past(wb_dat_i[15])) else $error("vector select not written");
  a_level_req: assert property (irq_req_o == (irq_level_o != 3'h0))
    else $error("request and level disagree");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_req_o && !wb_ack_o &&
    !alt_vector_select_o && irq_level_o == 3'h0 && irq_src_o == 4'h0)
    else $error("outputs not cleared by reset");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_flag_read: cover property (rd && wa == 1 && wb_dat_o != 32'h0);
  c_irq: cover property ($rose(irq_req_o));
  c_alt: cover property ($rose(alt_vector_select_o));
endmodule
bind ifec_top ifec_top_monitor #(.ADR_W(ADR_W)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flags_zero_req_i(flags_zero_req_i),
  .flags_one_req_i(flags_one_req_i), .flags_four_req_i(flags_four_req_i),
  .ext_pin_i(ext_pin_i), .irq_hold_instr_active_i(irq_hold_instr_active_i),
  .alt_vector_select_o(alt_vector_select_o), .irq_req_o(irq_req_o),
  .irq_level_o(irq_level_o), .irq_src_o(irq_src_o));

/* File: dv/ifec_src_model.sv */
/* Model of the peripheral request sources, the pins and the core status.
   Assumes the bench commands it at the rising edge of the one clock. */
`timescale 1ns/1ns
module ifec_src_model (
  input  wire         clk_i,
  input  wire         go_i,
  input  wire  [15:0] pat0_i,
  input  wire  [15:0] pat1_i,
  input  wire  [15:0] pat4_i,
  input  wire  [2:0]  pins_i,
  input  wire         hold_i,
  output logic [15:0] req0_o = 16'h0000,
  output logic [15:0] req1_o = 16'h0000,
  output logic [15:0] req4_o = 16'h0000,
  output logic [2:0]  pin_o = 3'h0,
  output logic        hold_o = 1'b0
);
  // ----------
  // Pulse shaping
  // ----------
  // Requests last only as long as go_i is held, so a stuck source cannot hide a failed clear.
  always @(posedge clk_i) begin
    req0_o <= go_i ? pat0_i : 16'h0000;
    req1_o <= go_i ? pat1_i : 16'h0000;
    req4_o <= go_i ? pat4_i : 16'h0000;
    pin_o  <= pins_i;
    hold_o <= hold_i;
  end
endmodule

/* File: dv/test_ifec_top.sv */
/* Self-checking bench for ifec_top with a register model in the bench.
   Assumes one 100 MHz clock and the offsets of the constants header. */
`timescale 1ns/1ns
`include "ifec_consts.vh"
module test_ifec_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, hold = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, src;
  logic [31:0] wdat = 32'h0, rdat, dato, seed = 32'd84505;
  logic        ack, irq, alt;
  logic [2:0]  lvl, pins = 3'h0, pw;
  logic [15:0] p0 = 16'h0, p1 = 16'h0, p4 = 16'h0, r0, r1, r4;
  logic [15:0] m_f0, m_f1, m_f4, m_en, m_ctl;
  logic [2:0]  m_pr [0:15];
  wire         hw;
  integer      errors = 0, compares = 0, ticks = 0;
  always #5 clk_i = ~clk_i;
  ifec_src_model src_u (.clk_i(clk_i), .go_i(go), .pat0_i(p0), .pat1_i(p1), .pat4_i(p4),
    .pins_i(pins), .hold_i(hold), .req0_o(r0), .req1_o(r1), .req4_o(r4), .pin_o(pw),
    .hold_o(hw));
  ifec_top #(.ADR_W(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato),
    .wb_ack_o(ack), .flags_zero_req_i(r0), .flags_one_req_i(r1), .flags_four_req_i(r4),
    .ext_pin_i(pw), .irq_hold_instr_active_i(hw), .alt_vector_select_o(alt),
    .irq_req_o(irq), .irq_level_o(lvl), .irq_src_o(src));
  // ----------
  // Model and bus tasks
  // ----------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Lane-wise merge; lanes 2 and 3 carry nothing.
  function automatic logic [15:0] ln(input logic [15:0] o, d, m, input logic [3:0] s);
    logic [15:0] k;
    k = {{8{s[1]}}, {8{s[0]}}} & m;
    return (o & ~k) | (d & k);
  endfunction
  task automatic mreset;
    {m_f0, m_f1, m_f4, m_en, m_ctl} = 80'h0;
    for (int i = 0; i < 16; i++) m_pr[i] = `IFEC_RST_PRIO;
  endtask
  task automatic mwr(input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    logic [15:0] t;
    t = ln({13'h0, m_pr[a[5:2]]}, d, 16'h0007, s);
    case (a[7:2])
      0: m_ctl = ln(m_ctl, d, `IFEC_CTL_WR_MASK, s);
      1: m_f0 = ln(m_f0, d, `IFEC_F0_MASK, s);
      2: m_f1 = ln(m_f1, d, `IFEC_F1_MASK, s);
      3: m_f4 = ln(m_f4, d, `IFEC_F4_MASK, s);
      4: m_en = ln(m_en, d, `IFEC_EN0_MASK, s);
      default: if (a[6]) m_pr[a[5:2]] = t[2:0];
    endcase
  endtask
  function automatic logic [31:0] mrd(input logic [7:0] a);
    case (a[7:2])
      0: return {16'h0, m_ctl[15], hold, 11'h000, m_ctl[2:0]};
      1: return {16'h0, m_f0};
      2: return {16'h0, m_f1};
      3: return {16'h0, m_f4};
      4: return {16'h0, m_en};
      default: return a[6] ? {29'h0, m_pr[a[5:2]]} : 32'h0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic cycle: held until ack is sampled, then released for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [15:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 16'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dato;
    {cyc, stb} <= 2'b00;
    if (w) mwr(a, s, d);
  endtask
  task automatic rc(input logic [7:0] a);
    wb(1'b0, a, 4'h3, 16'h0);
    chk("register read", mrd(a), rdat);
    chk("vector select output", {31'h0, m_ctl[15]}, {31'h0, alt});
  endtask
  task automatic pulse(input logic [15:0] a, b);
    @(posedge clk_i);
    {go, p0, p1, p4} <= {1'b1, a, b, a};
    @(posedge clk_i);
    go <= 1'b0;
    m_f0 = m_f0 | (a & 16'h3fee);
    m_f1 = m_f1 | (b & 16'h00cb);
    m_f4 = m_f4 | (a & 16'h0002);
    repeat (3) @(posedge clk_i);
  endtask
  // A pin flag is set when the new level equals the inverse of its polarity.
  task automatic pin(input logic [2:0] v);
    logic [2:0] e;
    e = (pins ^ v) & ~(v ^ ~m_ctl[2:0]);
    @(posedge clk_i);
    pins <= v;
    repeat (4) @(posedge clk_i);
    m_f0[0] = m_f0[0] | e[0];
    m_f1[4] = m_f1[4] | e[1];
    m_f1[13] = m_f1[13] | e[2];
  endtask
  task automatic irq_chk;
    logic [2:0] b;
    logic [3:0] s;
    b = 3'h0;
    s = 4'h0;
    for (int i = 0; i < 16; i++) if (m_f0[i] && m_en[i] && m_pr[i] > b) begin
      b = m_pr[i];
      s = i[3:0];
    end
    chk("irq outputs", {24'h0, b != 0, b, s}, {24'h0, irq, lvl, src});
  endtask
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // Reset twice so that the mid-run reset is checked as well as power-on.
  initial begin
    mreset();
    for (int r = 0; r < 2; r++) begin
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      mreset();
      for (int a = 0; a < 'h80; a += 4) rc(a[7:0]);
      for (int a = 0; a < 'h14; a += 4) begin
        wb(1'b1, a[7:0], 4'h3, 16'hffff);
        rc(a[7:0]);
      end
      for (int i = 0; i < 40; i++) begin
        seed = xs(seed);
        wb(1'b1, {1'b0, seed[6:2], 2'b00}, seed[10:7], seed[31:16]);
        rc({1'b0, seed[6:2], 2'b00});
      end
    end
    // Flags from every peripheral request source, gated by enables and priorities.
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      wb(1'b1, 8'h04, 4'h3, 16'h0);
      wb(1'b1, 8'h10, 4'h3, seed[15:0]);
      wb(1'b1, {2'b01, seed[19:16], 2'b00}, 4'h1, {13'h0, seed[22:20]});
      pulse(xs(seed) & (i[0] ? 16'h2000 : 16'hffff), seed[31:16]);
      irq_chk();
      rc(8'h04);
      rc(8'h08);
      rc(8'h0c);
    end
    // Every polarity mix against rising and falling pin edges.
    foreach (seed[k]) if (k < 8) begin
      wb(1'b1, 8'h00, 4'h3, {13'h0, k[2:0]});
      wb(1'b1, 8'h04, 4'h3, 16'h0);
      wb(1'b1, 8'h08, 4'h3, 16'h0);
      for (int v = 0; v < 4; v++) begin
        pin(v[0] ? 3'h7 : 3'h0);
        rc(8'h04);
        rc(8'h08);
        irq_chk();
      end
    end
    for (int h = 1; h >= 0; h--) begin
      hold <= h[0];
      repeat (4) @(posedge clk_i);
      rc(8'h00);
    end
    give_verdict();
  end
endmodule
